// *** sem_regs.svh ***
// Purpose: Offsets, field positions, reset values of the event monitor registers
// Assumes: Byte-wide registers on an 8-bit register address
// Notes:   Definitions only
`ifndef SEM_REGS_SVH
`define SEM_REGS_SVH
// ==========================================================
// Register offsets
`define SEM_OFS_MASK    8'h27
`define SEM_OFS_LOSCTL  8'h28
`define SEM_OFS_LOSSTS  8'h29
`define SEM_OFS_DETECT  8'h2a
`define SEM_OFS_CFG     8'h2b
`define SEM_OFS_TALLY   8'h2c
`define SEM_OFS_DRIVER  8'h2e
// ==========================================================
// Field positions
`define SEM_MSK_PLL     4
`define SEM_MSK_FIFO    3
`define SEM_MSK_CDET    2
`define SEM_MSK_CLOS    1
`define SEM_MSK_DLOS    0
`define SEM_LOS_PRESET  1
`define SEM_LOS_CLEAR   0
`define SEM_CFG_NOPLL   6
`define SEM_CFG_NOLINK  5
`define SEM_CFG_NOLOS   4
`define SEM_CFG_SEL     3
`define SEM_CFG_CLRPLL  2
`define SEM_CFG_CLRLINK 1
`define SEM_CFG_EN      0
`define SEM_DRV_REV     6
// ==========================================================
// Reset values and counter saturation limit
`define SEM_RST_MASK    8'h00
`define SEM_RST_LOSCTL  2'h0
`define SEM_RST_LOSSTS  6'h00
`define SEM_RST_CFG     7'h00
`define SEM_RST_DRIVER  7'h00
`define SEM_RST_COUNT   8'h00
`define SEM_COUNT_MAX   8'hff
`endif

// *** sem_pkg.sv ***
// Purpose: Types shared by the event monitor register bank
// Assumes: Nothing beyond the register header
// Notes:   Types only; constants live in sem_regs.svh
package sem_pkg;
  // ==========================================================
  // Register access request from the management bus front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sem_req_t;
  // ==========================================================
  // Event and loss sources from the serializer datapath
  typedef struct packed {
    logic       pll_lock_event;
    logic       link_event;
    logic       pll_error;
    logic       fifo_error;
    logic       clk_detect_error;
    logic       clk_loss;
    logic [4:0] data_loss;
  } sem_events_t;
  // ==========================================================
  // Live detection levels
  typedef struct packed {
    logic       clk_detected;
    logic [1:0] link_detected;
  } sem_detect_t;
  typedef enum logic {
    SEM_SEL_PLL  = 1'b0,
    SEM_SEL_LINK = 1'b1
  } sem_sel_t;
endpackage

// *** sem_sat_counter.sv ***
// Purpose: 8-bit saturating event counter with synchronous clear
// Assumes: inc is a single-cycle qualified event
// Notes:   Clear wins over an increment in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "sem_regs.svh"
module sem_sat_counter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       inc,
  output var  logic [7:0] count
);
  // ==========================================================
  // Saturating step
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    if (v == `SEM_COUNT_MAX)
    begin
      return v;
    end
    return v + 8'h01;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= `SEM_RST_COUNT;
    end
    else if (clear)
    begin
      count <= `SEM_RST_COUNT;
    end
    else if (inc)
    begin
      count <= sat_inc(count);
    end
  end
endmodule
`default_nettype wire

// *** sem_event_monitor_regs.sv ***
// Purpose: Status and event monitoring register bank of the serializer
// Assumes: Register requests come from the management bus front end,
//          synchronous to clk; event inputs are single-cycle pulses, loss inputs are levels
// Notes:   Read data is registered and appears one edge after the request
`timescale 1ns/1ps
`default_nettype none
`include "sem_regs.svh"
module sem_event_monitor_regs (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire sem_pkg::sem_req_t   bus_req,
  input  wire sem_pkg::sem_events_t events,
  input  wire sem_pkg::sem_detect_t detect,
  output var  logic [7:0]          reg_rdata,
  output var  logic                reg_rvalid,
  output var  logic                reverse_data_order,
  output var  logic [1:0]          link_detect_value,
  output var  logic [5:0]          loss_flags,
  output var  logic                count_enable
);
  // ==========================================================
  // Storage
  logic [7:0] error_count_mask;
  logic [1:0] loss_flag_control;
  logic [6:0] event_counter_setup;
  logic [3:0] driver_spare;
  logic       clk_loss_q;
  logic [4:0] data_loss_q;
  logic [7:0] pll_count;
  logic [7:0] link_count;
  logic [5:0] next_loss_flags;
  logic [7:0] next_rdata;
  logic       clk_los_edge;
  logic       data_los_edge;
  logic       pll_qual;
  logic       link_qual;
  logic       los_allowed;
  sem_pkg::sem_sel_t count_sel;

  // ==========================================================
  // Decode helpers
  function automatic logic wr_hit(
    input sem_pkg::sem_req_t r,
    input logic [7:0]        a
  );
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic rising(
    input logic now,
    input logic was
  );
    return now && !was;
  endfunction

  // ==========================================================
  // Error count mask
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      error_count_mask <= `SEM_RST_MASK;
    end
    else if (wr_hit(bus_req, `SEM_OFS_MASK))
    begin
      error_count_mask <= bus_req.wdata;
    end
  end

  // ==========================================================
  // Loss flag control
  // Bits act as levels while set, so software writes 0 to release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loss_flag_control <= `SEM_RST_LOSCTL;
    end
    else if (wr_hit(bus_req, `SEM_OFS_LOSCTL))
    begin
      loss_flag_control <= bus_req.wdata[1:0];
    end
  end

  // ==========================================================
  // Loss flags
  // A loss seen in the clearing cycle still sets its flag
  always_comb
  begin
    next_loss_flags = loss_flags;
    if (loss_flag_control[`SEM_LOS_PRESET])
    begin
      next_loss_flags = 6'h3f;
    end
    else if (loss_flag_control[`SEM_LOS_CLEAR])
    begin
      next_loss_flags = 6'h00;
    end
    next_loss_flags[5] = next_loss_flags[5] | events.clk_loss;
    next_loss_flags[4:0] = next_loss_flags[4:0] | events.data_loss;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loss_flags <= `SEM_RST_LOSSTS;
    end
    else
    begin
      loss_flags <= next_loss_flags;
    end
  end

  // ==========================================================
  // Event counter setup
  // Clear bits stay high for one cycle, then drop by themselves
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_counter_setup <= `SEM_RST_CFG;
    end
    else if (wr_hit(bus_req, `SEM_OFS_CFG))
    begin
      event_counter_setup <= bus_req.wdata[6:0];
    end
    else
    begin
      event_counter_setup[`SEM_CFG_CLRPLL] <= 1'b0;
      event_counter_setup[`SEM_CFG_CLRLINK] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_enable <= 1'b0;
    end
    else if (wr_hit(bus_req, `SEM_OFS_CFG))
    begin
      count_enable <= bus_req.wdata[`SEM_CFG_EN];
    end
  end

  // ==========================================================
  // Driver register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reverse_data_order <= 1'b0;
      link_detect_value  <= 2'h0;
      driver_spare       <= 4'h0;
    end
    else if (wr_hit(bus_req, `SEM_OFS_DRIVER))
    begin
      reverse_data_order <= bus_req.wdata[`SEM_DRV_REV];
      link_detect_value  <= bus_req.wdata[1:0];
      driver_spare       <= bus_req.wdata[5:2];
    end
  end

  // ==========================================================
  // Loss edges
  // Levels are counted once per onset, not once per cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_loss_q  <= 1'b0;
      data_loss_q <= 5'h00;
    end
    else
    begin
      clk_loss_q  <= events.clk_loss;
      data_loss_q <= events.data_loss;
    end
  end

  assign clk_los_edge  = rising(events.clk_loss, clk_loss_q);
  assign data_los_edge = |(events.data_loss & ~data_loss_q);

  // ==========================================================
  // Event qualification
  // Several sources in one cycle add only one count
  assign los_allowed = !event_counter_setup[`SEM_CFG_NOLOS];

  always_comb
  begin
    pll_qual = 1'b0;
    if (events.pll_lock_event && !event_counter_setup[`SEM_CFG_NOPLL])
    begin
      pll_qual = 1'b1;
    end
    if (events.pll_error && !error_count_mask[`SEM_MSK_PLL])
    begin
      pll_qual = 1'b1;
    end
    if (events.clk_detect_error && !error_count_mask[`SEM_MSK_CDET])
    begin
      pll_qual = 1'b1;
    end
    if (clk_los_edge && los_allowed && !error_count_mask[`SEM_MSK_CLOS])
    begin
      pll_qual = 1'b1;
    end
    pll_qual = pll_qual && count_enable;
  end

  always_comb
  begin
    link_qual = 1'b0;
    if (events.link_event && !event_counter_setup[`SEM_CFG_NOLINK])
    begin
      link_qual = 1'b1;
    end
    if (events.fifo_error && !error_count_mask[`SEM_MSK_FIFO])
    begin
      link_qual = 1'b1;
    end
    if (data_los_edge && los_allowed && !error_count_mask[`SEM_MSK_DLOS])
    begin
      link_qual = 1'b1;
    end
    link_qual = link_qual && count_enable;
  end

  // ==========================================================
  // Counters
  sem_sat_counter u_pll_count (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (event_counter_setup[`SEM_CFG_CLRPLL]),
    .inc   (pll_qual),
    .count (pll_count)
  );

  sem_sat_counter u_link_count (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (event_counter_setup[`SEM_CFG_CLRLINK]),
    .inc   (link_qual),
    .count (link_count)
  );

  // ==========================================================
  // Read mux
  // Unmapped offsets read as zero
  assign count_sel = sem_pkg::sem_sel_t'(event_counter_setup[`SEM_CFG_SEL]);

  always_comb
  begin
    next_rdata = 8'h00;
    case (bus_req.addr)
      `SEM_OFS_MASK:
      begin
        next_rdata = error_count_mask;
      end
      `SEM_OFS_LOSCTL:
      begin
        next_rdata = {6'h00, loss_flag_control};
      end
      `SEM_OFS_LOSSTS:
      begin
        next_rdata = {2'h0, loss_flags};
      end
      `SEM_OFS_DETECT:
      begin
        next_rdata = {4'h0, detect.clk_detected, 1'b0, detect.link_detected};
      end
      `SEM_OFS_CFG:
      begin
        next_rdata = {1'b0, event_counter_setup};
      end
      `SEM_OFS_TALLY:
      begin
        if (count_sel == sem_pkg::SEM_SEL_LINK)
        begin
          next_rdata = link_count;
        end
        else
        begin
          next_rdata = pll_count;
        end
      end
      `SEM_OFS_DRIVER:
      begin
        next_rdata = {1'b0, reverse_data_order, driver_spare, link_detect_value};
      end
      default:
      begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // Read return
  // Data holds until the next read so a slow front end can fetch it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (bus_req.rd)
    begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= bus_req.rd;
    end
  end
endmodule
`default_nettype wire

// *** sem_monitor_asserts.sv ***
// Purpose: Port-level checks of the event monitor register bank
// Assumes: One clock domain, bench keeps one idle cycle after loss writes
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "sem_regs.svh"
module sem_monitor_asserts (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire sem_pkg::sem_req_t    bus_req,
  input wire sem_pkg::sem_events_t events,
  input wire sem_pkg::sem_detect_t detect,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 reg_rvalid,
  input wire logic                 reverse_data_order,
  input wire logic [1:0]           link_detect_value,
  input wire logic [5:0]           loss_flags,
  input wire logic                 count_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Access sequences
  sequence wr_at(logic [7:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // ==========================================
  // Checks
  flags_read_a: assert property (rd_at(`SEM_OFS_LOSSTS) |=>
    reg_rvalid && reg_rdata == {2'b00, $past(loss_flags)})
    else $error("loss flag read wrong");
  detect_read_a: assert property (rd_at(`SEM_OFS_DETECT) |=> reg_rdata ==
    {4'h0, $past(detect.clk_detected), 1'b0, $past(detect.link_detected)})
    else $error("detect read wrong");
  clk_loss_a: assert property (events.clk_loss |=> loss_flags[5])
    else $error("clock loss flag missing");
  lane_loss_a: assert property (|events.data_loss |=>
    (loss_flags[4:0] & $past(events.data_loss)) == $past(events.data_loss))
    else $error("lane loss flag missing");
  preset_a: assert property (wr_at(`SEM_OFS_LOSCTL) ##0 bus_req.wdata[1]
    |-> ##2 loss_flags == 6'h3f)
    else $error("preset did not set flags");
  clear_a: assert property (wr_at(`SEM_OFS_LOSCTL) ##0 bus_req.wdata[1:0] == 2'b01
    ##1 (!events.clk_loss && events.data_loss == 5'h00) |=> loss_flags == 6'h00)
    else $error("clear did not clear flags");
  driver_wr_a: assert property (wr_at(`SEM_OFS_DRIVER) |=>
    reverse_data_order == $past(bus_req.wdata[6])
    && link_detect_value == $past(bus_req.wdata[1:0]))
    else $error("driver outputs wrong");
  enable_wr_a: assert property (wr_at(`SEM_OFS_CFG) |=>
    count_enable == $past(bus_req.wdata[0]))
    else $error("count enable wrong");
endmodule
bind sem_event_monitor_regs sem_monitor_asserts u_sem_monitor_asserts (
  .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .events(events), .detect(detect),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reverse_data_order(reverse_data_order),
  .link_detect_value(link_detect_value), .loss_flags(loss_flags),
  .count_enable(count_enable));
`default_nettype wire

// *** sem_event_monitor_regs_bench.sv ***
// Purpose: Self-checking bench of the event monitor register bank
// Assumes: One access every other cycle at most
// Notes:   Expected values come from the register map only
`timescale 1ns/1ps
`default_nettype none
`include "sem_regs.svh"
module sem_event_monitor_regs_bench;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  sem_pkg::sem_req_t    req = '0;
  sem_pkg::sem_events_t ev = '0;
  sem_pkg::sem_detect_t det = '0;
  logic [7:0]           rdata;
  logic                 rvalid;
  logic                 rev;
  logic                 en;
  logic [1:0]           ldv;
  logic [5:0]           flags;
  int                   failures = 0;
  int                   tests_run = 0;
  int                   cycles = 0;
  always #50 clk = ~clk;
  sem_event_monitor_regs u_sem_event_monitor_regs (
    .clk(clk), .rst_n(rst_n), .bus_req(req), .events(ev), .detect(det),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .reverse_data_order(rev),
    .link_detect_value(ldv), .loss_flags(flags), .count_enable(en));
  // ==========================================
  // Shared tasks
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    // Let the written register settle before any caller looks at it
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask
  // High for n cycles, one event per high cycle
  task automatic pulse(sem_pkg::sem_events_t e, int n);
    @(posedge clk);
    ev <= e;
    repeat (n) @(posedge clk);
    ev <= '0;
  endtask
  // Masked source must not count, unmasked must count once
  task automatic src(sem_pkg::sem_events_t e, logic [7:0] a, logic [7:0] m, logic s);
    logic [7:0] base;
    base = {4'h0, s, 3'h1};
    wr(`SEM_OFS_CFG, base | 8'h06);
    wr(a, (a == `SEM_OFS_CFG) ? base | m : m);
    pulse(e, 1);
    rd(`SEM_OFS_TALLY, 8'h00);
    wr(a, (a == `SEM_OFS_CFG) ? base : 8'h00);
    pulse(e, 1);
    rd(`SEM_OFS_TALLY, 8'h01);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] ofs [8];
    ofs = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    foreach (ofs[i]) if (ofs[i] inside {8'h29, 8'h2a, 8'h2c, 8'h2d}) wr(ofs[i], 8'hff);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(`SEM_OFS_MASK, 8'hff);
    rd(`SEM_OFS_MASK, 8'hff);
    wr(`SEM_OFS_MASK, 8'h00);
    wr(`SEM_OFS_DRIVER, 8'hff);
    rd(`SEM_OFS_DRIVER, 8'h7f);
    check({5'h00, rev, ldv}, 8'h07);
    wr(`SEM_OFS_DRIVER, 8'h01);
    check({5'h00, rev, ldv}, 8'h01);
    det <= 3'b110;
    rd(`SEM_OFS_DETECT, 8'h0a);
    det <= 3'b001;
    rd(`SEM_OFS_DETECT, 8'h01);
    $display("done registers");
  endtask
  task automatic t_loss();
    @(posedge clk);
    ev <= 11'h035;
    rd(`SEM_OFS_LOSSTS, 8'h35);
    ev <= '0;
    rd(`SEM_OFS_LOSSTS, 8'h35);
    wr(`SEM_OFS_LOSCTL, 8'h01);
    wr(`SEM_OFS_LOSCTL, 8'h00);
    rd(`SEM_OFS_LOSSTS, 8'h00);
    wr(`SEM_OFS_LOSCTL, 8'h02);
    rd(`SEM_OFS_LOSSTS, 8'h3f);
    check({2'b00, flags}, 8'h3f);
    wr(`SEM_OFS_LOSCTL, 8'h01);
    rd(`SEM_OFS_LOSSTS, 8'h00);
    rd(`SEM_OFS_LOSCTL, 8'h01);
    wr(`SEM_OFS_LOSCTL, 8'h00);
    $display("done loss flags");
  endtask
  task automatic t_count();
    src(11'h400, `SEM_OFS_CFG, 8'h40, 1'b0);
    src(11'h100, `SEM_OFS_MASK, 8'h10, 1'b0);
    src(11'h040, `SEM_OFS_MASK, 8'h04, 1'b0);
    src(11'h020, `SEM_OFS_MASK, 8'h02, 1'b0);
    src(11'h020, `SEM_OFS_CFG, 8'h10, 1'b0);
    src(11'h001, `SEM_OFS_CFG, 8'h10, 1'b1);
    src(11'h001, `SEM_OFS_MASK, 8'h01, 1'b1);
    src(11'h080, `SEM_OFS_MASK, 8'h08, 1'b1);
    src(11'h200, `SEM_OFS_CFG, 8'h20, 1'b1);
    wr(`SEM_OFS_CFG, 8'h05);
    wr(`SEM_OFS_CFG, 8'h00);
    check({7'h00, en}, 8'h00);
    pulse(11'h400, 2);
    rd(`SEM_OFS_TALLY, 8'h00);
    wr(`SEM_OFS_CFG, 8'h01);
    pulse(11'h400, 260);
    rd(`SEM_OFS_TALLY, 8'hff);
    wr(`SEM_OFS_CFG, 8'h09);
    rd(`SEM_OFS_TALLY, 8'h01);
    wr(`SEM_OFS_CFG, 8'h01);
    rd(`SEM_OFS_TALLY, 8'hff);
    wr(`SEM_OFS_CFG, 8'h05);
    rd(`SEM_OFS_CFG, 8'h01);
    rd(`SEM_OFS_TALLY, 8'h00);
    wr(`SEM_OFS_CFG, 8'h0b);
    rd(`SEM_OFS_CFG, 8'h09);
    rd(`SEM_OFS_TALLY, 8'h00);
    $display("done counters");
  endtask
  // ==========================================
  // Run control
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Whole run takes about 510 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_loss();
    t_count();
    complete_run();
  end
endmodule
`default_nettype wire
